// file: hdl/ptrs_defs.svh
`ifndef PTRS_DEFS_SVH
`define PTRS_DEFS_SVH

// ----------------------------------------
// sub function codes
// ----------------------------------------
`define PTRS_SUB_SINGLE     4'h0
`define PTRS_SUB_CONT       4'h1
`define PTRS_SUB_VARY       4'h3
`define PTRS_SUB_RPT_START  4'h8
`define PTRS_SUB_RPT_FIRST  4'h9
`define PTRS_SUB_VRPT_A     4'hA
`define PTRS_SUB_VRPT_B     4'hB

// ----------------------------------------
// command method and table
// ----------------------------------------
`define PTRS_INCR_DIGIT     4'h1
`define PTRS_FIRST_ENTRY    1
`define PTRS_TABLE_DEPTH    16

// ----------------------------------------
// timing
// ----------------------------------------
`define PTRS_CLK_PERIOD_NS  50
`define PTRS_DWELL_UNIT_NS  1000000
`define PTRS_MS_CYCLES      (`PTRS_DWELL_UNIT_NS / `PTRS_CLK_PERIOD_NS)

`endif

// file: hdl/ptrs_dwell_timer.sv
`timescale 1ns/10ps
module ptrs_dwell_timer #(
  parameter int MS_CYCLES = 20000,
  parameter int MSW       = 16
) (
  input  wire logic           i_core_clk,
  input  wire logic           i_nrst,
  input  wire logic           i_go,
  input  wire logic [MSW-1:0] i_ms,
  output logic                o_done
);

  localparam int CW = $clog2(MS_CYCLES + 1);

  logic [CW-1:0]  sub_q;
  logic [CW-1:0]  sub_d;
  logic [MSW-1:0] ms_q;
  logic [MSW-1:0] ms_d;
  logic           busy_q;
  logic           busy_d;
  logic           done_q;
  logic           done_d;

  always_comb begin
    sub_d  = sub_q;
    ms_d   = ms_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (i_go) begin
      sub_d  = '0;
      ms_d   = i_ms;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (ms_q == '0) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else if (sub_q == CW'(MS_CYCLES - 1)) begin
        sub_d = '0;
        ms_d  = ms_q - MSW'(1);
      end else begin
        sub_d = sub_q + CW'(1);
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sub_q  <= '0;
      ms_q   <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      sub_q  <= sub_d;
      ms_q   <= ms_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign o_done = done_q;

endmodule

// file: hdl/ptrs_pkg.sv
package ptrs_pkg;

  typedef struct packed {
    logic signed [31:0] pos;
    logic [15:0]        speed;
    logic [15:0]        accel;
    logic [15:0]        decel;
    logic [15:0]        dwell;
    logic [3:0]         subfn;
  } ptrs_entry_t;

  typedef struct packed {
    logic signed [31:0] pos;
    logic [15:0]        speed;
    logic [15:0]        accel;
    logic [15:0]        decel;
    logic               incr;
    logic               fwd;
    logic               blend;
  } ptrs_move_t;

  typedef enum logic [1:0] {
    PTRS_IDLE  = 2'b00,
    PTRS_ISSUE = 2'b01,
    PTRS_RUN   = 2'b10,
    PTRS_DWELL = 2'b11
  } ptrs_state_t;

endpackage

// file: hdl/ptrs_sequencer.sv
// Function
// [R1] method digit one means incremental data
// [R2] incremental code 8 restarts at start entry
// [R3] incremental code 9 restarts at entry one
// [R4] absolute varying chain code 8 restarts forward
// [R5] incremental code 10 blends into entry one
// [R6] varying-speed entries chain without stopping
// [R7] code 8 repeat returns to the start entry rather than to entry one; the start entry may be entry one
// [R8] host ends plain chains with code zero
// [R9] restart waits for completion and dwell
`timescale 1ns/10ps
`include "ptrs_defs.svh"
module ptrs_sequencer import ptrs_pkg::*; #(
  parameter int DEPTH     = `PTRS_TABLE_DEPTH,
  parameter int IW        = $clog2(DEPTH),
  parameter int MS_CYCLES = `PTRS_MS_CYCLES
) (
  input  wire logic          i_core_clk,
  input  wire logic          i_nrst,
  input  wire logic          i_tbl_we,
  input  wire logic [IW-1:0] i_tbl_idx,
  input  wire ptrs_entry_t   i_tbl_data,
  input  wire logic [3:0]    i_command_method_select,
  input  wire logic          i_fwd_start,
  input  wire logic          i_rev_start,
  input  wire logic          i_stop,
  input  wire logic [IW-1:0] i_start_idx,
  input  wire logic          i_motion_done,
  output ptrs_move_t         o_move,
  output logic               o_move_valid,
  output logic               o_busy,
  output logic [IW-1:0]      o_cur_idx,
  output logic               o_travel_done
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // the table number is multi-bit; the host holds it steady around the start edge
  logic [2:0]    pin_s1_q;
  logic [2:0]    pin_s2_q;
  logic [1:0]    pin_s3_q;
  logic [IW-1:0] idx_s1_q;
  logic [IW-1:0] idx_s2_q;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      pin_s3_q <= 2'h0;
      idx_s1_q <= '0;
      idx_s2_q <= '0;
    end else begin
      pin_s1_q <= {i_stop, i_rev_start, i_fwd_start};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q[1:0];
      idx_s1_q <= i_start_idx;
      idx_s2_q <= idx_s1_q;
    end
  end

  logic fwd_edge;
  logic rev_edge;
  logic stop_lvl;
  assign fwd_edge = pin_s2_q[0] & ~pin_s3_q[0];
  assign rev_edge = pin_s2_q[1] & ~pin_s3_q[1];
  assign stop_lvl = pin_s2_q[2];

  // ----------------------------------------
  // point table storage
  // ----------------------------------------
  ptrs_entry_t tbl_mem [DEPTH];

  always_ff @(posedge i_core_clk) begin
    if (i_tbl_we) begin
      tbl_mem[i_tbl_idx] <= i_tbl_data;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  ptrs_state_t   state_q;
  ptrs_state_t   state_d;
  logic [IW-1:0] cur_q;
  logic [IW-1:0] cur_d;
  logic [IW-1:0] start_q;
  logic [IW-1:0] start_d;
  logic          fwd_q;
  logic          fwd_d;
  ptrs_move_t    move_q;
  ptrs_move_t    move_d;
  logic          valid_q;
  logic          valid_d;
  logic          done_q;
  logic          done_d;
  logic          dwell_go;
  logic          dwell_done;

  ptrs_entry_t   ent;
  logic          incr;
  logic          blend;
  logic          nxt_end;
  logic          nxt_fwd;
  logic [IW-1:0] nxt_idx;
  logic [IW-1:0] inc_idx;

  assign ent     = tbl_mem[cur_q];
  assign incr    = (i_command_method_select == `PTRS_INCR_DIGIT);  // [R1]
  assign inc_idx = cur_q + IW'(1);
  // code 3 entries, and code 10 entries under incremental data, hand over without a stop or dwell
  assign blend   = (ent.subfn == `PTRS_SUB_VARY) ||
                   (incr && (ent.subfn == `PTRS_SUB_VRPT_A));  // [R6] [R5]

  // choice of the entry that follows the current one
  always_comb begin
    nxt_end = 1'b0;
    nxt_fwd = fwd_q;
    nxt_idx = inc_idx;
    case (ent.subfn)
      `PTRS_SUB_CONT, `PTRS_SUB_VARY: begin
        nxt_end = (inc_idx == '0);
      end
      `PTRS_SUB_RPT_START: begin
        nxt_idx = start_q;  // [R2] [R7]
        if (!incr) begin
          nxt_fwd = 1'b1;  // [R4]
        end
      end
      `PTRS_SUB_RPT_FIRST: begin
        nxt_idx = IW'(`PTRS_FIRST_ENTRY);  // [R3]
      end
      `PTRS_SUB_VRPT_A: begin
        nxt_idx = incr ? IW'(`PTRS_FIRST_ENTRY) : start_q;  // [R5]
      end
      `PTRS_SUB_VRPT_B: begin
        nxt_idx = IW'(`PTRS_FIRST_ENTRY);
      end
      default: begin
        nxt_end = 1'b1;  // code zero and unknown codes end the run
      end
    endcase
  end

  always_comb begin
    state_d  = state_q;
    cur_d    = cur_q;
    start_d  = start_q;
    fwd_d    = fwd_q;
    move_d   = move_q;
    valid_d  = 1'b0;
    done_d   = done_q;
    dwell_go = 1'b0;
    case (state_q)
      PTRS_IDLE: begin
        // entry zero is not a point table, so a start naming it is ignored
        if ((fwd_edge || rev_edge) && !stop_lvl && (idx_s2_q != '0)) begin
          cur_d   = idx_s2_q;
          start_d = idx_s2_q;
          fwd_d   = fwd_edge;
          done_d  = 1'b0;
          state_d = PTRS_ISSUE;
        end
      end
      PTRS_ISSUE: begin
        move_d.pos   = ent.pos;
        move_d.speed = ent.speed;
        move_d.accel = ent.accel;
        move_d.decel = ent.decel;
        move_d.incr  = incr;  // [R1]
        move_d.fwd   = fwd_q;
        move_d.blend = blend;  // [R6]
        valid_d      = 1'b1;
        state_d      = PTRS_RUN;
      end
      PTRS_RUN: begin
        if (i_motion_done) begin
          if (blend && !nxt_end) begin
            cur_d   = nxt_idx;  // [R6]
            fwd_d   = nxt_fwd;
            state_d = PTRS_ISSUE;
          end else begin
            dwell_go = 1'b1;  // [R9]
            state_d  = PTRS_DWELL;
          end
        end
      end
      PTRS_DWELL: begin
        if (dwell_done) begin
          if (nxt_end) begin
            done_d  = 1'b1;
            state_d = PTRS_IDLE;
          end else begin
            cur_d   = nxt_idx;  // [R9]
            fwd_d   = nxt_fwd;
            state_d = PTRS_ISSUE;
          end
        end
      end
      default: begin
        state_d = PTRS_IDLE;
      end
    endcase
    // a stop request abandons the pattern; the motion side decelerates on its own
    // entry and command hold their last values, so no move changes without a valid pulse
    if (stop_lvl && (state_q != PTRS_IDLE)) begin
      state_d  = PTRS_IDLE;
      cur_d    = cur_q;
      move_d   = move_q;
      valid_d  = 1'b0;
      done_d   = 1'b1;
      dwell_go = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= PTRS_IDLE;
      cur_q   <= '0;
      start_q <= '0;
      fwd_q   <= 1'b1;
      move_q  <= '0;
      valid_q <= 1'b0;
      done_q  <= 1'b1;
    end else begin
      state_q <= state_d;
      cur_q   <= cur_d;
      start_q <= start_d;
      fwd_q   <= fwd_d;
      move_q  <= move_d;
      valid_q <= valid_d;
      done_q  <= done_d;
    end
  end

  ptrs_dwell_timer #(
    .MS_CYCLES (MS_CYCLES),
    .MSW       (16)
  ) u_dwell (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_go       (dwell_go),
    .i_ms       (ent.dwell),
    .o_done     (dwell_done)
  );

  assign o_move        = move_q;
  assign o_move_valid  = valid_q;
  assign o_busy        = (state_q != PTRS_IDLE);
  assign o_cur_idx     = cur_q;
  assign o_travel_done = done_q;

endmodule

// file: tb/ptrs_motion_model.sv
`timescale 1ns/10ps
module ptrs_motion_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_move_valid,
  input  wire logic [3:0] i_lat,
  output logic            o_done
);
  logic [3:0] cnt_q;
  logic       run_q;
  // one done pulse per segment, lat+1 cycles after its command (two cycles when lat is zero)
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q  <= 4'h0;
      run_q  <= 1'b0;
      o_done <= 1'b0;
    end else if (i_move_valid) begin
      cnt_q  <= i_lat;
      run_q  <= 1'b1;
      o_done <= 1'b0;
    end else if (run_q && cnt_q <= 4'h1) begin
      run_q  <= 1'b0;
      o_done <= 1'b1;
    end else begin
      cnt_q  <= cnt_q - 4'h1;
      o_done <= 1'b0;
    end
  end
endmodule

// file: tb/ptrs_seq_asserts.sv
`timescale 1ns/10ps
module ptrs_seq_asserts import ptrs_pkg::*; #(
  parameter int DEPTH     = 16,
  parameter int IW        = 4,
  parameter int MS_CYCLES = 4
) (
  input wire logic          i_core_clk,
  input wire logic          i_nrst,
  input wire logic          i_tbl_we,
  input wire logic [IW-1:0] i_tbl_idx,
  input wire ptrs_entry_t   i_tbl_data,
  input wire logic [3:0]    i_command_method_select,
  input wire logic          i_fwd_start,
  input wire logic          i_rev_start,
  input wire logic          i_stop,
  input wire logic [IW-1:0] i_start_idx,
  input wire logic          i_motion_done,
  input wire ptrs_move_t    o_move,
  input wire logic          o_move_valid,
  input wire logic          o_busy,
  input wire logic [IW-1:0] o_cur_idx,
  input wire logic          o_travel_done
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // ----------------------------------------
  // steps
  // ----------------------------------------
  sequence start_seen;
    $rose(o_busy);
  endsequence
  sequence seg_end;
    o_busy && !o_move_valid && i_motion_done;
  endsequence
  // the next command leaves through the issue state, two cycles after completion
  sequence blend_issue;
    !o_move_valid [*2] ##1 o_move_valid;
  endsequence
  property blend_chain;
    disable iff (!i_nrst || i_stop) seg_end and (o_move.blend && !(&o_cur_idx)) |-> blend_issue;
  endproperty
  property dwell_first;
    disable iff (!i_nrst || i_stop) seg_end and !o_move.blend |=> !o_move_valid [*3];
  endproperty
  property idx_issue;
    disable iff (!i_nrst || i_stop) o_busy && $changed(o_cur_idx) |=> o_move_valid;
  endproperty
  // ----------------------------------------
  // checks
  // ----------------------------------------
  // stop may land mid-segment, so the blend, dwell and index-hold checks stand down while it is high
  start_answer_a: assert property (start_seen |=> o_move_valid && !o_travel_done)
    else $error("no move after start");
  blend_gap_a: assert property (blend_chain)
    else $error("blend not chained");
  dwell_wait_a: assert property (dwell_first)
    else $error("restart before dwell");
  method_incr_a: assert property (o_move_valid |-> o_move.incr == (i_command_method_select == 4'h1))
    else $error("method bit wrong");
  idx_nonzero_a: assert property (o_move_valid |-> |o_cur_idx) else $error("entry zero issued");
  idx_hold_a: assert property (idx_issue) else $error("entry moved");
  move_hold_a: assert property (!o_move_valid |-> $stable(o_move)) else $error("move changed");
  end_flag_a: assert property ($fell(o_busy) |-> ##[0:2] o_travel_done) else $error("no travel done");
endmodule

bind ptrs_sequencer ptrs_seq_asserts #(.DEPTH(DEPTH), .IW(IW), .MS_CYCLES(MS_CYCLES)) u_chk (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_tbl_we(i_tbl_we), .i_tbl_idx(i_tbl_idx),
  .i_tbl_data(i_tbl_data), .i_command_method_select(i_command_method_select),
  .i_fwd_start(i_fwd_start), .i_rev_start(i_rev_start), .i_stop(i_stop), .i_start_idx(i_start_idx),
  .i_motion_done(i_motion_done), .o_move(o_move), .o_move_valid(o_move_valid), .o_busy(o_busy),
  .o_cur_idx(o_cur_idx), .o_travel_done(o_travel_done));

// file: tb/ptrs_sequencer_bench.sv
`timescale 1ns/10ps
module ptrs_sequencer_bench import ptrs_pkg::*;;
  logic        clk, nrst, we, fwd, rev, stop, done, valid, busy, tdone;
  logic [3:0]  idx, meth, sidx, cur, lat;
  ptrs_entry_t data;
  ptrs_move_t  move;
  int          n_errors, samples_checked;

  ptrs_sequencer #(.MS_CYCLES(4)) DUT (.i_core_clk(clk), .i_nrst(nrst), .i_tbl_we(we), .i_tbl_idx(idx),
    .i_tbl_data(data), .i_command_method_select(meth), .i_fwd_start(fwd), .i_rev_start(rev), .i_stop(stop),
    .i_start_idx(sidx), .i_motion_done(done), .o_move(move), .o_move_valid(valid), .o_busy(busy),
    .o_cur_idx(cur), .o_travel_done(tdone));
  ptrs_motion_model u_motion (.i_core_clk(clk), .i_nrst(nrst), .i_move_valid(valid), .i_lat(lat), .o_done(done));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // speed carries the entry number so each segment shows its own speed
  task automatic put(input logic [3:0] n, input logic [3:0] s);
    @(negedge clk);
    we = 1'b1;
    idx = n;
    data = '{pos: {28'h0, n}, speed: {4'h0, n, 8'h00}, accel: 16'h0010, decel: 16'h0010, dwell: 16'h0001, subfn: s};
    @(negedge clk);
    we = 1'b0;
  endtask
  task automatic go(input logic [3:0] m, input logic [3:0] n, input logic r);
    @(negedge clk);
    meth = m;
    sidx = n;
    repeat (3) @(negedge clk);
    fwd = !r;
    rev = r;
    repeat (2) @(negedge clk);
    fwd = 1'b0;
    rev = 1'b0;
  endtask
  task automatic step(input logic [3:0] n);
    int k;
    k = 0;
    while (valid !== 1'b1 && k < 300) begin
      @(negedge clk);
      k++;
    end
    if (k == 300) begin
      n_errors++;
      test_done;
    end
    chk("entry", 32'(cur), 32'(n));
    chk("speed", 32'(move.speed), {20'h0, n, 8'h00});
    chk("pos", 32'(move.pos), {28'h0, n});
    chk("ramps", 32'({move.accel, move.decel}), 32'h00100010);
    @(negedge clk);
  endtask
  task automatic halt;
    int k;
    k = 0;
    stop = 1'b1;
    while (!(tdone === 1'b1 && busy === 1'b0) && k < 60) begin
      @(negedge clk);
      k++;
    end
    chk("halt", 32'({busy, tdone}), 32'h1);
    stop = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_incr8;
    put(4'h1, 4'h1);
    put(4'h2, 4'h1);
    put(4'h3, 4'h8);
    lat = 4'h1;
    go(4'h1, 4'h2, 1'b0);
    step(4'h2); step(4'h3); step(4'h2); step(4'h3);
    chk("incr", 32'(move.incr), 32'h1);
    halt;
  endtask
  task automatic t_incr9;
    put(4'h1, 4'h1);
    put(4'h2, 4'h9);
    lat = 4'h5;
    go(4'h1, 4'h2, 1'b0);
    step(4'h2); step(4'h1); step(4'h2); step(4'h1);
    halt;
  endtask
  task automatic t_abs8;
    put(4'h1, 4'h3);
    put(4'h2, 4'h3);
    put(4'h3, 4'h8);
    lat = 4'h1;
    go(4'h0, 4'h1, 1'b1);
    step(4'h1);
    chk("fwd0", 32'(move.fwd), 32'h0);
    chk("blend", 32'(move.blend), 32'h1);
    step(4'h2); step(4'h3); step(4'h1);
    chk("fwd", 32'(move.fwd), 32'h1);
    chk("incr", 32'(move.incr), 32'h0);
    step(4'h2);
    halt;
  endtask
  task automatic t_incr10;
    put(4'h1, 4'h3);
    put(4'h2, 4'h1);
    put(4'h3, 4'hA);
    lat = 4'h2;
    go(4'h1, 4'h1, 1'b0);
    step(4'h1); step(4'h2); step(4'h3); step(4'h1); step(4'h2);
    chk("blend", 32'(move.blend), 32'h0);
    halt;
  endtask
  // code 11 restarts at entry one after completion and dwell
  task automatic t_abs11;
    put(4'h1, 4'h1);
    put(4'h2, 4'hB);
    lat = 4'h1;
    go(4'h0, 4'h2, 1'b0);
    step(4'h2); step(4'h1); step(4'h2); step(4'h1);
    chk("incr", 32'(move.incr), 32'h0);
    halt;
  endtask
  task automatic t_plain;
    int k;
    go(4'h0, 4'h0, 1'b0);
    repeat (8) @(negedge clk);
    chk("refused", 32'({busy, tdone}), 32'h1);
    put(4'h1, 4'h1);
    put(4'h2, 4'h0);
    go(4'h0, 4'h1, 1'b0);
    step(4'h1); step(4'h2);
    k = 0;
    while (busy !== 1'b0 && k < 60) begin
      @(negedge clk);
      k++;
    end
    repeat (3) @(negedge clk);
    chk("end", 32'({busy, tdone}), 32'h1);
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {nrst, we, fwd, rev, stop} = 5'h0;
    {idx, meth, sidx, lat} = 16'h0001;
    data = '0;
    n_errors = 0;
    samples_checked = 0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    t_incr8;
    t_incr9;
    t_abs8;
    t_incr10;
    t_abs11;
    t_plain;
    test_done;
  end
endmodule
